// ---- rtl/buck3_regs_pkg.sv ----
// package: offsets, field positions, defaults and carriers for the buck3 limit registers
package buck3_regs_pkg;
  localparam logic [7:0] primary_voltage_offset = 8'h0a;
  localparam logic [7:0] alt_voltage_offset = 8'h0b;
  localparam logic [7:0] range_ceiling_offset = 8'h0c;
  localparam int enable_pos = 7;
  localparam int economy_pos = 6;
  localparam int source_select_pos = 6;
  localparam int range_pos = 6;
  localparam logic [5:0] ceiling_all_ones = 6'h3f;
  localparam logic [5:0] ceiling_all_zeros = 6'h00;
  localparam logic [7:0] primary_voltage_reset = 8'h36;
  localparam logic [7:0] alt_voltage_reset = 8'h00;
  localparam logic [7:0] range_ceiling_reset = 8'hff;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic enable;
    logic economy;
    logic [1:0] range;
    logic [5:0] code;
  } buck_ctrl_type;
endpackage

// ---- rtl/buck3_voltage_limit_regs.sv ----
// buck3 primary-voltage, alternate-voltage and range/ceiling register bank
`timescale 1ns/10ps
module buck3_voltage_limit_regs
  import buck3_regs_pkg::*;
#(
  parameter logic [7:0] otp_primary = primary_voltage_reset,
  parameter logic [7:0] otp_alt = alt_voltage_reset,
  parameter logic [7:0] otp_limit = range_ceiling_reset
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // register access from the serial control bus decoder
  input wire reg_req_type req,
  output logic [7:0] rdata,
  // converter status input
  input wire logic buck3_forced_mode_bit,
  // converter control outputs
  output buck_ctrl_type ctrl
);

  // -----------------------------------------------------------------
  // register state
  // -----------------------------------------------------------------
  logic [7:0] buck3_primary_voltage, next_primary;
  logic [7:0] buck3_alt_voltage_ctrl, next_alt;
  logic [7:0] buck3_range_and_ceiling, next_limit;
  logic [7:0] next_rdata;
  buck_ctrl_type next_ctrl;
  logic locked;

  // -----------------------------------------------------------------
  // ceiling lock and clamp
  // -----------------------------------------------------------------
  // clamping acts at write time only, so a ceiling lowered later leaves stored codes alone
  // clamp a code to the ceiling
  function automatic logic [5:0] clamp(input logic [5:0] code, input logic [5:0] ceil);
    clamp = (code > ceil) ? ceil : code;
  endfunction

  // the limit locks itself once the ceiling is neither all ones nor all zeros
  assign locked = (buck3_range_and_ceiling[5:0] != ceiling_all_ones) &&
                  (buck3_range_and_ceiling[5:0] != ceiling_all_zeros);

  // -----------------------------------------------------------------
  // register writes
  // -----------------------------------------------------------------
  // next register values from writes
  always_comb
  begin
    next_primary = buck3_primary_voltage;
    next_alt = buck3_alt_voltage_ctrl;
    next_limit = buck3_range_and_ceiling;
    if (req.wr && req.addr == primary_voltage_offset)
    begin
      next_primary = {1'b0, req.wdata[source_select_pos],
                      clamp(req.wdata[5:0], buck3_range_and_ceiling[5:0])};
    end
    if (req.wr && req.addr == alt_voltage_offset)
    begin
      next_alt = {req.wdata[enable_pos], req.wdata[economy_pos],
                  clamp(req.wdata[5:0], buck3_range_and_ceiling[5:0])};
    end
    if (req.wr && req.addr == range_ceiling_offset && !locked)
    begin
      next_limit = req.wdata;
    end
  end

  // register file, loaded with the programmed defaults in reset
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      buck3_primary_voltage <= otp_primary;
      buck3_alt_voltage_ctrl <= otp_alt;
      buck3_range_and_ceiling <= otp_limit;
    end
    else
    begin
      buck3_primary_voltage <= next_primary;
      buck3_alt_voltage_ctrl <= next_alt;
      buck3_range_and_ceiling <= next_limit;
    end
  end

  // defaults come back on every reset
  AST_RESET_LOAD: assert property (@(posedge mclk)
    !reset_n |=> buck3_primary_voltage == otp_primary && buck3_alt_voltage_ctrl == otp_alt &&
      buck3_range_and_ceiling == otp_limit)
    else $error("register missed its default");

  // a locked limit keeps its contents, an open one takes the write whole
  AST_LOCK_HOLDS: assert property (@(posedge mclk) disable iff (!reset_n)
    locked && req.wr && req.addr == range_ceiling_offset |=> $stable(buck3_range_and_ceiling))
    else $error("locked limit register changed");
  AST_LIMIT_WRITE: assert property (@(posedge mclk) disable iff (!reset_n)
    !locked && req.wr && req.addr == range_ceiling_offset |=> buck3_range_and_ceiling == $past(req.wdata))
    else $error("unlocked limit write lost");

  // codes are clamped against the ceiling held at the time of the write
  AST_ALT_CLAMP: assert property (@(posedge mclk) disable iff (!reset_n)
    req.wr && req.addr == alt_voltage_offset |=>
    buck3_alt_voltage_ctrl[5:0] <= $past(buck3_range_and_ceiling[5:0]))
    else $error("alternate code above ceiling");
  AST_PRI_CLAMP: assert property (@(posedge mclk) disable iff (!reset_n)
    req.wr && req.addr == primary_voltage_offset |=>
    buck3_primary_voltage[5:0] <= $past(buck3_range_and_ceiling[5:0]))
    else $error("primary code above ceiling");

  // control bits land as written
  AST_ALT_BITS: assert property (@(posedge mclk) disable iff (!reset_n)
    req.wr && req.addr == alt_voltage_offset |=>
    buck3_alt_voltage_ctrl[enable_pos] == $past(req.wdata[enable_pos]) &&
    buck3_alt_voltage_ctrl[economy_pos] == $past(req.wdata[economy_pos]))
    else $error("alternate control bits not stored");
  AST_SELECT_BIT: assert property (@(posedge mclk) disable iff (!reset_n)
    req.wr && req.addr == primary_voltage_offset |=>
    buck3_primary_voltage[source_select_pos] == $past(req.wdata[source_select_pos]))
    else $error("source select not stored");

  // nothing moves without a write, and the unused top bit stays clear
  AST_ALT_HOLDS: assert property (@(posedge mclk) disable iff (!reset_n)
    !(req.wr && req.addr == alt_voltage_offset) |=> $stable(buck3_alt_voltage_ctrl))
    else $error("alternate register changed without a write");
  AST_PRI_HOLDS: assert property (@(posedge mclk) disable iff (!reset_n)
    !(req.wr && req.addr == primary_voltage_offset) |=> $stable(buck3_primary_voltage))
    else $error("primary register changed without a write");
  AST_RESERVED: assert property (@(posedge mclk) disable iff (!reset_n)
    !buck3_primary_voltage[7])
    else $error("reserved bit set");

  // -----------------------------------------------------------------
  // read data
  // -----------------------------------------------------------------
  // read mux, zero when idle or unmapped
  always_comb
  begin
    next_rdata = 8'h00;
    if (req.rd)
    begin
      case (req.addr)
        primary_voltage_offset: next_rdata = buck3_primary_voltage;
        alt_voltage_offset: next_rdata = buck3_alt_voltage_ctrl;
        range_ceiling_offset: next_rdata = buck3_range_and_ceiling;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // read data register, one cycle after the strobe
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      rdata <= 8'h00;
    end
    else
    begin
      rdata <= next_rdata;
    end
  end

  // a locked limit still reads back as stored
  AST_READBACK: assert property (@(posedge mclk) disable iff (!reset_n)
    req.rd && req.addr == range_ceiling_offset |=> rdata == $past(buck3_range_and_ceiling))
    else $error("limit readback wrong");

  // -----------------------------------------------------------------
  // converter controls
  // -----------------------------------------------------------------
  // controls follow the next register values so they move together with them
  always_comb
  begin
    next_ctrl.enable = next_alt[enable_pos];
    next_ctrl.economy = next_alt[economy_pos] & ~buck3_forced_mode_bit;
    next_ctrl.range = next_limit[7:range_pos];
    next_ctrl.code = next_primary[source_select_pos] ? next_alt[5:0] : next_primary[5:0];
  end

  // control output register
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      ctrl <= '0;
    end
    else
    begin
      ctrl <= next_ctrl;
    end
  end

  // ctrl is cleared in reset and mirrors the registers from the first active edge on,
  // so these checks skip the cycle right after a reset
  AST_ENABLE_OUT: assert property (@(posedge mclk) disable iff (!reset_n)
    $past(reset_n) |-> ctrl.enable == buck3_alt_voltage_ctrl[enable_pos])
    else $error("enable output mismatch");
  // economy is gated by the forced-mode level of the cycle before
  AST_ECONOMY: assert property (@(posedge mclk) disable iff (!reset_n)
    $past(reset_n) |->
    ctrl.economy == (buck3_alt_voltage_ctrl[economy_pos] & ~$past(buck3_forced_mode_bit)))
    else $error("economy output mismatch");
  AST_RANGE: assert property (@(posedge mclk) disable iff (!reset_n)
    $past(reset_n) |-> ctrl.range == buck3_range_and_ceiling[7:range_pos])
    else $error("range output mismatch");
  // the source select picks which stored code drives the converter
  AST_SOURCE: assert property (@(posedge mclk) disable iff (!reset_n)
    $past(reset_n) |-> ctrl.code == (buck3_primary_voltage[source_select_pos] ?
                  buck3_alt_voltage_ctrl[5:0] : buck3_primary_voltage[5:0]))
    else $error("voltage source mismatch");

endmodule

// ---- test/host_model.sv ----
// host model that issues single-cycle register requests
`timescale 1ns/10ps
module host_model
  import buck3_regs_pkg::*;
(
  // clock
  input wire logic mclk,
  // request towards the register bank
  output reg_req_type req
);
  // idle until the bench asks for an access
  initial req = '0;

  // one strobe per access, dropped at the next edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{wr: w, rd: !w, addr: a, wdata: (a == primary_voltage_offset) ? (d & 8'h7f) : d};
    @(posedge mclk);
    req <= '0;
  endtask
endmodule

// ---- test/tb.sv ----
// self-checking bench for the buck3 primary-voltage, alternate-voltage and range/ceiling registers
`timescale 1ns/10ps
module tb;
  import buck3_regs_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic forced = 1'b0;
  logic rd_prev = 1'b0;
  logic [7:0] rdata;
  logic [5:0] c;
  logic [7:0] exp_q[$];
  buck_ctrl_type ctrl;
  reg_req_type req;
  int err_total = 0;
  int check_count = 0;
  integer seed = 32'hd43eb33b;

  // clock and design
  always #4 mclk = ~mclk;
  host_model u_host (.mclk(mclk), .req(req));
  buck3_voltage_limit_regs u_dut (.mclk(mclk), .reset_n(reset_n), .req(req), .rdata(rdata),
    .buck3_forced_mode_bit(forced), .ctrl(ctrl));

  // compare seen against expected
  task automatic check(input logic [9:0] s, input logic [9:0] e);
    check_count++;
    if (s !== e)
    begin
      $display("unexpected at %0t: got %h want %h", $time, s, e);
      err_total++;
    end
  endtask

  // control word implied by the reset defaults
  function automatic logic [9:0] reset_ctrl(input logic f);
    reset_ctrl = {alt_voltage_reset[enable_pos], alt_voltage_reset[economy_pos] & ~f,
                  range_ceiling_reset[7:range_pos],
                  (primary_voltage_reset[source_select_pos] ? alt_voltage_reset[5:0] : primary_voltage_reset[5:0])};
  endfunction

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.acc(1'b0, a, 8'h00);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.acc(1'b1, a, d);
  endtask

  // read data is compared one cycle after its strobe
  always @(posedge mclk)
  begin
    if (rd_prev)
      check({2'b00, rdata}, {2'b00, exp_q.pop_front()});
    rd_prev <= req.rd;
  end

  task automatic results();
    if (err_total == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // watchdog against a hang
  initial
  begin
    #20000;
    err_total++;
    results();
  end

  // main sequence
  initial
  begin
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    rd(range_ceiling_offset, range_ceiling_reset);
    rd(alt_voltage_offset, alt_voltage_reset);
    rd(primary_voltage_offset, primary_voltage_reset);
    check(ctrl, reset_ctrl(forced));
    wr(primary_voltage_offset, 8'hc0);
    wr(alt_voltage_offset, 8'hff);
    @(posedge mclk);
    #1 check(ctrl, 10'h3ff);
    rd(alt_voltage_offset, 8'hff);
    @(posedge mclk) forced <= 1'b1;
    @(posedge mclk);
    #1 check(ctrl, 10'h2ff);
    wr(range_ceiling_offset, 8'h85);
    wr(alt_voltage_offset, 8'h50);
    @(posedge mclk);
    #1 check(ctrl, 10'h085);
    rd(alt_voltage_offset, 8'h45);
    wr(range_ceiling_offset, 8'hff);
    rd(range_ceiling_offset, 8'h85);
    rd(8'h20, 8'h00);
    repeat (8)
    begin
      c = 6'($random(seed));
      wr(primary_voltage_offset, {2'b00, c});
      rd(primary_voltage_offset, {2'b00, (c > 6'h05) ? 6'h05 : c});
    end
    // second reset mid-run: the locked limit must come back open
    @(posedge mclk) reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    rd(range_ceiling_offset, range_ceiling_reset);
    rd(alt_voltage_offset, alt_voltage_reset);
    rd(primary_voltage_offset, primary_voltage_reset);
    check(ctrl, reset_ctrl(forced));
    // an all-zero ceiling clamps to zero but leaves the limit open
    wr(range_ceiling_offset, 8'h40);
    wr(alt_voltage_offset, 8'h3f);
    rd(alt_voltage_offset, 8'h00);
    check(ctrl, {2'b00, 2'b01, primary_voltage_reset[5:0]});
    wr(range_ceiling_offset, 8'hff);
    rd(range_ceiling_offset, 8'hff);
    repeat (2) @(posedge mclk);
    results();
  end
endmodule
